// *** timer_cfg.svh ***
`ifndef TIMER_CFG_SVH
`define TIMER_CFG_SVH

// ============================================================
// Register indices (byte address is four times the index)
`define IDX_TIMER_CONTROL 8'h91
`define IDX_LOW_RELOAD 8'h92
`define IDX_HIGH_RELOAD 8'h93
`define IDX_LOW_COUNT 8'h94
`define IDX_HIGH_COUNT 8'h95
`define IDX_CLOCK_CONTROL 8'h96

// ============================================================
// Timer control register fields
`define CTRL_HIGH_OVF_BIT 7
`define CTRL_LOW_OVF_BIT 6
`define CTRL_LOW_IE_BIT 5
`define CTRL_CAPTURE_BIT 4
`define CTRL_SPLIT_BIT 3
`define CTRL_RUN_BIT 2
`define CTRL_EXT_SEL_BIT 0

// ============================================================
// Clock control register fields
`define CKC_HIGH_SEL_BIT 7
`define CKC_LOW_SEL_BIT 6

// ============================================================
// Reset values
`define RST_BYTE 8'h00
`define RST_WORD 32'h0000_0000

// ============================================================
// Clock divisors
`define SYS_DIVIDE 12
`define EXT_DIVIDE 8

`endif

// *** timer_pkg.sv ***
package timer_pkg;

    // ========================================================
    // Clock source state
    typedef struct packed {
        logic [3:0] prescale;
        logic ext_meta;
        logic ext_sync;
        logic ext_prev;
        logic [2:0] ext_count;
        logic tick_div12;
        logic tick_ext8;
        logic capture;
    } clk_state_t;

    // ========================================================
    // Timer and bus state
    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic [7:0] low_count_byte;
        logic [7:0] high_count_byte;
        logic [7:0] low_reload_byte;
        logic [7:0] high_reload_byte;
        logic high_overflow_flag;
        logic low_overflow_flag;
        logic low_byte_interrupt_enable;
        logic capture_mode_enable;
        logic split_mode_bit;
        logic run_bit;
        logic external_clock_select;
        logic high_byte_clock_select;
        logic low_byte_clock_select;
    } timer_state_t;

endpackage

// *** timer_clk_src.sv ***
`timescale 1ns/1ns
`include "timer_cfg.svh"

module timer_clk_src
(
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // External oscillator
    input wire logic ext_osc_i,
    // Rate enables
    output logic tick_div12_o,
    output logic tick_ext8_o,
    output logic capture_o
);

    timer_pkg::clk_state_t s_reg;
    timer_pkg::clk_state_t s_next;

    // ========================================================
    // Dividers
    always_comb
    begin
        s_next = s_reg;
        s_next.tick_div12 = 1'b0;
        s_next.tick_ext8 = 1'b0;
        s_next.capture = 1'b0;
        // System clock divided by 12
        if (s_reg.prescale == 4'(`SYS_DIVIDE - 1))
        begin
            s_next.prescale = 4'h0;
            s_next.tick_div12 = 1'b1; // [R03]
        end
        else
        begin
            s_next.prescale = s_reg.prescale + 4'h1;
        end
        // Two stages; only the second is looked at
        s_next.ext_meta = ext_osc_i;
        s_next.ext_sync = s_reg.ext_meta; // [R03]
        s_next.ext_prev = s_reg.ext_sync;
        if (s_reg.ext_sync && !s_reg.ext_prev)
        begin
            s_next.ext_count = s_reg.ext_count + 3'h1;
            // Divided clock rises at count 4, falls back at 0
            if (s_reg.ext_count == 3'(`EXT_DIVIDE / 2 - 1))
            begin
                s_next.tick_ext8 = 1'b1; // [R03]
            end
            if (s_reg.ext_count == 3'(`EXT_DIVIDE - 1))
            begin
                s_next.capture = 1'b1; // [R17]
            end
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            s_reg <= '0;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign tick_div12_o = s_reg.tick_div12;
    assign tick_ext8_o = s_reg.tick_ext8;
    assign capture_o = s_reg.capture;

endmodule // timer_clk_src

// *** auto_reload_timer.sv ***
// Notes on behaviour
// (R01) Sixteen-bit count from two addressable bytes
// (R02) Split bit three picks dual 8-bit
// (R03) Sources: system, system/12, synced external/8
// (R04) 16-bit rollover reloads and sets high flag
// (R05) 16-bit overflow requests interrupt when enabled
// (R06) Low byte rollover also interrupts if bit5
// (R07) Split: each byte reloads from own byte
// (R08) Split: run gates high byte only
// (R09) High clock: select bit, else external choice
// (R10) Low clock chosen alike by own bit
// (R11) Split: each byte rollover sets its flag
// (R12) Split: high interrupts; bit5 adds low
// (R13) Flags stay set until software clears
// (R14) Software reads both flags, clears them
// (R15) Capture clock: system or system/12 only
// (R16) Capture copies count to reloads, high flag
// (R17) Capture on falling edge of external/8
// (R18) Software measures by capture difference
// (R19) Software keeps 16-bit mode for capture
// (R20) Control bit four enables capture mode
// (R21) Run bit two starts and stops counting
// (R22) Reset clears counts, reloads, flags, controls
//
// Implementation choices: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ns
`include "timer_cfg.svh"

module auto_reload_timer
(
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // Avalon-MM slave
    input wire logic [9:0] address_i,
    input wire logic read_i,
    input wire logic write_i,
    input wire logic [31:0] writedata_i,
    output logic [31:0] readdata_o,
    output logic waitrequest_o,
    // External oscillator
    input wire logic ext_osc_i,
    // Interrupt
    input wire logic timer_int_enable_i,
    output logic timer_irq_o
);

    timer_pkg::timer_state_t s_reg;
    timer_pkg::timer_state_t s_next;

    logic tick_div12;
    logic tick_ext8;
    logic capture_event;
    logic tick_low;
    logic tick_high;
    logic [7:0] index;
    logic [7:0] wbyte;
    logic do_write;
    logic [15:0] count16;
    // Interrupt causes
    logic high_req;
    logic low_req;

    // Everything idle: stopped, 16-bit mode, flags clear
    localparam timer_pkg::timer_state_t reset_state = '{
        ack: 1'b0,
        rdata: `RST_WORD,
        low_count_byte: `RST_BYTE,
        high_count_byte: `RST_BYTE,
        low_reload_byte: `RST_BYTE,
        high_reload_byte: `RST_BYTE,
        default: 1'b0
    };

    // ========================================================
    // Clock sources
    // Dividers live outside so both bytes share one phase
    timer_clk_src u_clk_src
    (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .ext_osc_i(ext_osc_i),
        .tick_div12_o(tick_div12),
        .tick_ext8_o(tick_ext8),
        .capture_o(capture_event)
    );

    // ========================================================
    // Helpers

    // Count enable for one byte from its select bits
    function automatic logic pick_tick(
        input logic sys_sel,
        input logic ext_sel,
        input logic capture_on,
        input logic div12,
        input logic ext8
    );
        logic t;
        t = 1'b0;
        if (sys_sel)
        begin
            t = 1'b1; // [R09] [R10]
        end
        else if (ext_sel && !capture_on)
        begin
            t = ext8; // [R09] [R10]
        end
        else
        begin
            // Measured clock cannot also time itself
            t = div12; // [R15]
        end
        return t;
    endfunction

    // Register read mux
    function automatic logic [7:0] read_byte(
        input logic [7:0] idx,
        input timer_pkg::timer_state_t st
    );
        logic [7:0] v;
        v = 8'h00;
        unique case (idx)
            `IDX_TIMER_CONTROL:
            begin
                v[`CTRL_HIGH_OVF_BIT] = st.high_overflow_flag;
                v[`CTRL_LOW_OVF_BIT] = st.low_overflow_flag;
                v[`CTRL_LOW_IE_BIT] = st.low_byte_interrupt_enable;
                v[`CTRL_CAPTURE_BIT] = st.capture_mode_enable;
                v[`CTRL_SPLIT_BIT] = st.split_mode_bit;
                v[`CTRL_RUN_BIT] = st.run_bit;
                v[`CTRL_EXT_SEL_BIT] = st.external_clock_select;
            end
            `IDX_LOW_RELOAD:
            begin
                v = st.low_reload_byte;
            end
            `IDX_HIGH_RELOAD:
            begin
                v = st.high_reload_byte;
            end
            // No snapshot: a running count may tear across two reads
            `IDX_LOW_COUNT:
            begin
                v = st.low_count_byte; // [R01]
            end
            `IDX_HIGH_COUNT:
            begin
                v = st.high_count_byte; // [R01]
            end
            `IDX_CLOCK_CONTROL:
            begin
                v[`CKC_HIGH_SEL_BIT] = st.high_byte_clock_select;
                v[`CKC_LOW_SEL_BIT] = st.low_byte_clock_select;
            end
            default:
            begin
                // Unmapped reads as zero
                v = 8'h00;
            end
        endcase
        return v;
    endfunction

    // ========================================================
    // Decode
    assign index = address_i[9:2];
    assign wbyte = writedata_i[7:0];
    // A write lands only at the edge that answers it
    assign do_write = write_i && s_reg.ack;
    assign count16 = {s_reg.high_count_byte, s_reg.low_count_byte};

    always_comb
    begin
        tick_low = pick_tick(s_reg.low_byte_clock_select, s_reg.external_clock_select,
                             s_reg.capture_mode_enable, tick_div12, tick_ext8);
        tick_high = pick_tick(s_reg.high_byte_clock_select, s_reg.external_clock_select,
                              1'b0, tick_div12, tick_ext8);
    end

    // ========================================================
    // Next state
    always_comb
    begin
        logic set_high;
        logic set_low;
        logic [15:0] c16;
        set_high = 1'b0;
        set_low = 1'b0;
        c16 = count16;
        s_next = s_reg;

        // Bus answer: one wait cycle, then waitrequest drops
        s_next.ack = (read_i || write_i) && !s_reg.ack;
        if (read_i && !s_reg.ack)
        begin
            s_next.rdata = {24'h00_0000, read_byte(index, s_reg)};
        end

        // Counting
        if (!s_reg.split_mode_bit)
        begin
            // Single 16-bit timer, clocked by the low select
            if (s_reg.run_bit && tick_low) // [R02] [R21]
            begin
                if (s_reg.low_count_byte == 8'hFF)
                begin
                    set_low = 1'b1; // [R06]
                end
                // Whole word wraps: both bytes reload at once
                if (count16 == 16'hFFFF)
                begin
                    c16 = {s_reg.high_reload_byte, s_reg.low_reload_byte}; // [R04]
                    set_high = 1'b1; // [R04]
                end
                else
                begin
                    c16 = count16 + 16'h0001;
                end
            end
            s_next.low_count_byte = c16[7:0];
            s_next.high_count_byte = c16[15:8];
        end
        else
        begin
            // Low byte free runs in split mode
            if (tick_low) // [R08]
            begin
                if (s_reg.low_count_byte == 8'hFF)
                begin
                    s_next.low_count_byte = s_reg.low_reload_byte; // [R07]
                    set_low = 1'b1; // [R11]
                end
                else
                begin
                    s_next.low_count_byte = s_reg.low_count_byte + 8'h01;
                end
            end
            if (s_reg.run_bit && tick_high) // [R08] [R21]
            begin
                if (s_reg.high_count_byte == 8'hFF)
                begin
                    s_next.high_count_byte = s_reg.high_reload_byte; // [R07]
                    set_high = 1'b1; // [R11]
                end
                else
                begin
                    s_next.high_count_byte = s_reg.high_count_byte + 8'h01;
                end
            end
        end

        // Capture takes the count as it stands
        // Reloads take the capture even in an overflow cycle
        if (s_reg.capture_mode_enable && capture_event) // [R20]
        begin
            s_next.low_reload_byte = s_reg.low_count_byte; // [R16]
            s_next.high_reload_byte = s_reg.high_count_byte; // [R16]
            set_high = 1'b1; // [R16]
        end

        // Software writes; a write to a count byte wins over counting
        if (do_write)
        begin
            unique case (index)
                `IDX_TIMER_CONTROL:
                begin
                    s_next.high_overflow_flag = wbyte[`CTRL_HIGH_OVF_BIT];
                    s_next.low_overflow_flag = wbyte[`CTRL_LOW_OVF_BIT];
                    s_next.low_byte_interrupt_enable = wbyte[`CTRL_LOW_IE_BIT];
                    s_next.capture_mode_enable = wbyte[`CTRL_CAPTURE_BIT]; // [R20]
                    s_next.split_mode_bit = wbyte[`CTRL_SPLIT_BIT]; // [R02]
                    s_next.run_bit = wbyte[`CTRL_RUN_BIT]; // [R21]
                    s_next.external_clock_select = wbyte[`CTRL_EXT_SEL_BIT];
                end
                `IDX_LOW_RELOAD:
                begin
                    s_next.low_reload_byte = wbyte;
                end
                `IDX_HIGH_RELOAD:
                begin
                    s_next.high_reload_byte = wbyte;
                end
                `IDX_LOW_COUNT:
                begin
                    s_next.low_count_byte = wbyte; // [R01]
                end
                `IDX_HIGH_COUNT:
                begin
                    s_next.high_count_byte = wbyte; // [R01]
                end
                `IDX_CLOCK_CONTROL:
                begin
                    s_next.high_byte_clock_select = wbyte[`CKC_HIGH_SEL_BIT];
                    s_next.low_byte_clock_select = wbyte[`CKC_LOW_SEL_BIT];
                end
                default:
                begin
                    // Unmapped write is dropped
                    s_next.ack = s_next.ack;
                end
            endcase
        end

        // Hardware only sets; a set in the clearing cycle wins
        if (set_high)
        begin
            s_next.high_overflow_flag = 1'b1; // [R13]
        end
        if (set_low)
        begin
            s_next.low_overflow_flag = 1'b1; // [R13]
        end
    end

    // ========================================================
    // State register
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            s_reg <= reset_state; // [R22]
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    // ========================================================
    // Outputs
    assign readdata_o = s_reg.rdata;
    assign waitrequest_o = (read_i || write_i) && !s_reg.ack;

    // Level request; software must clear the flags to drop it
    always_comb
    begin
        high_req = s_reg.high_overflow_flag; // [R05] [R12]
        low_req = s_reg.low_byte_interrupt_enable && s_reg.low_overflow_flag; // [R06] [R12]
        // Shared line; software tells the two causes apart by the flags
        timer_irq_o = timer_int_enable_i && (high_req || low_req); // [R14]
    end

endmodule // auto_reload_timer

// *** auto_reload_timer_props.sv ***
`timescale 1ns/1ns
`include "timer_cfg.svh"

module auto_reload_timer_props
(
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // Bus
    input wire logic [9:0] address_i,
    input wire logic read_i,
    input wire logic write_i,
    input wire logic [31:0] writedata_i,
    input wire logic [31:0] readdata_o,
    input wire logic waitrequest_o,
    // Timer pins
    input wire logic ext_osc_i,
    input wire logic timer_int_enable_i,
    input wire logic timer_irq_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    // ==========================================
    // Bus handshake
    property p_one_wait;
        $rose(read_i | write_i) |-> waitrequest_o ##1 !waitrequest_o;
    endproperty
    a_one_wait: assert property (p_one_wait)
        else $error("wait state not exactly one");
    property p_ack_once;
        (read_i | write_i) && !waitrequest_o |=> waitrequest_o || !(read_i | write_i);
    endproperty
    a_ack_once: assert property (p_ack_once)
        else $error("answer given twice");
    property p_upper_zero;
        readdata_o[31:8] == 24'h00_0000;
    endproperty
    a_upper_zero: assert property (p_upper_zero)
        else $error("upper read bits not zero");
    // Read data only moves when a read was captured
    property p_rdata_hold;
        !$stable(readdata_o) |-> $past(read_i);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold)
        else $error("read data moved without read");
    property p_unmapped;
        read_i && !waitrequest_o && (address_i[9:2] < `IDX_TIMER_CONTROL
            || address_i[9:2] > `IDX_CLOCK_CONTROL) |-> readdata_o == 32'h0000_0000;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    property p_bit1_zero;
        read_i && !waitrequest_o && address_i[9:2] == `IDX_TIMER_CONTROL |-> !readdata_o[1];
    endproperty
    a_bit1_zero: assert property (p_bit1_zero)
        else $error("unused control bit reads one");

    // ==========================================
    // Interrupt request
    property p_irq_gate;
        !timer_int_enable_i |-> !timer_irq_o;
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("request while disabled");
    // Without a write the flags cannot drop
    property p_irq_sticky;
        timer_irq_o && !write_i ##1 timer_int_enable_i |-> timer_irq_o;
    endproperty
    a_irq_sticky: assert property (p_irq_sticky)
        else $error("request dropped without write");
endmodule // auto_reload_timer_props

bind auto_reload_timer auto_reload_timer_props auto_reload_timer_props_i (
    .mclk_i(mclk_i), .rst_i(rst_i), .address_i(address_i), .read_i(read_i),
    .write_i(write_i), .writedata_i(writedata_i), .readdata_o(readdata_o),
    .waitrequest_o(waitrequest_o), .ext_osc_i(ext_osc_i),
    .timer_int_enable_i(timer_int_enable_i), .timer_irq_o(timer_irq_o));

// *** tb.sv ***
`timescale 1ns/1ns
`include "timer_cfg.svh"

module tb;
    // ==========================================
    // Signals
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [9:0] address_i = 10'h000;
    logic read_i = 1'b0;
    logic write_i = 1'b0;
    logic [31:0] writedata_i = 32'h0000_0000;
    logic ext_osc_i = 1'b0;
    logic timer_int_enable_i = 1'b0;
    logic [31:0] readdata_o;
    logic waitrequest_o;
    logic timer_irq_o;
    logic [31:0] rd;
    int fail_count = 0;
    int n_tests = 0;

    auto_reload_timer auto_reload_timer_i (.mclk_i(mclk_i), .rst_i(rst_i),
        .address_i(address_i), .read_i(read_i), .write_i(write_i),
        .writedata_i(writedata_i), .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
        .ext_osc_i(ext_osc_i), .timer_int_enable_i(timer_int_enable_i),
        .timer_irq_o(timer_irq_o));

    initial
    begin
        forever #25 mclk_i = ~mclk_i;
    end
    // Oscillator free-running, off the mclk grid
    initial
    begin
        #7;
        forever #200 ext_osc_i = ~ext_osc_i;
    end

    // ==========================================
    // Shared tasks
    task end_of_test;
        $display("Checks %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi,
        input string what);
        n_tests++;
        if ((got >= lo && got <= hi) !== 1'b1)
        begin
            fail_count++;
            $display("MISMATCH at %0t: %s got %h", $time, what, got);
        end
    endtask
    // Held until waitrequest is seen low; the watchdog bounds the wait
    task xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        address_i <= {idx, 2'b00};
        writedata_i <= {24'h00_0000, wd};
        write_i <= wr;
        read_i <= !wr;
        do @(posedge mclk_i); while (waitrequest_o !== 1'b0);
        rd = readdata_o;
        read_i <= 1'b0;
        write_i <= 1'b0;
        // Idle edge so the strobe never toggles twice in one step
        @(posedge mclk_i);
    endtask
    task wr(input logic [7:0] idx, input logic [7:0] d);
        xfer(1'b1, idx, d);
    endtask
    task rdchk(input logic [7:0] idx, input logic [31:0] lo, input logic [31:0] hi,
        input string what);
        xfer(1'b0, idx, 8'h00);
        chk(rd, lo, hi, what);
    endtask

    // ==========================================
    // Scenarios
    task t_reset;
        for (int i = `IDX_TIMER_CONTROL; i <= `IDX_CLOCK_CONTROL; i++)
            rdchk(i[7:0], 8'h00, 8'h00, "reset value");
        wr(8'h90, 8'hFF);
        rdchk(8'h90, 8'h00, 8'h00, "unmapped");
        wr(`IDX_TIMER_CONTROL, 8'h02);
        rdchk(`IDX_TIMER_CONTROL, 8'h00, 8'h00, "unused bit");
        wr(`IDX_LOW_RELOAD, 8'hA5);
        wr(`IDX_HIGH_RELOAD, 8'h5A);
        wr(`IDX_LOW_COUNT, 8'h12);
        wr(`IDX_HIGH_COUNT, 8'h34);
        rdchk(`IDX_LOW_RELOAD, 8'hA5, 8'hA5, "low reload");
        rdchk(`IDX_HIGH_RELOAD, 8'h5A, 8'h5A, "high reload");
        rdchk(`IDX_LOW_COUNT, 8'h12, 8'h12, "low count");
        rdchk(`IDX_HIGH_COUNT, 8'h34, 8'h34, "high count");
    endtask
    // Split mode, run clear: low byte counts, high byte must hold
    task rate(input logic sel, input logic ext, input int n, input int lo, input int hi);
        wr(`IDX_CLOCK_CONTROL, {1'b0, sel, 6'h00});
        wr(`IDX_TIMER_CONTROL, {7'h04, ext});
        wr(`IDX_HIGH_COUNT, 8'h00);
        wr(`IDX_LOW_COUNT, 8'h00);
        repeat (n) @(posedge mclk_i);
        rdchk(`IDX_LOW_COUNT, lo, hi, "low rate");
        rdchk(`IDX_HIGH_COUNT, 8'h00, 8'h00, "high gated");
    endtask
    task t_rates;
        rate(1'b1, 1'b0, 200, 200, 204);
        rate(1'b0, 1'b0, 240, 19, 22);
        rate(1'b0, 1'b1, 640, 9, 12);
        wr(`IDX_CLOCK_CONTROL, 8'h80);
        wr(`IDX_TIMER_CONTROL, 8'h0C);
        wr(`IDX_HIGH_COUNT, 8'h00);
        repeat (100) @(posedge mclk_i);
        rdchk(`IDX_HIGH_COUNT, 100, 104, "high rate");
    endtask
    task t_split_ovf;
        timer_int_enable_i <= 1'b1;
        wr(`IDX_TIMER_CONTROL, 8'h08);
        wr(`IDX_LOW_RELOAD, 8'hF0);
        wr(`IDX_CLOCK_CONTROL, 8'hC0);
        wr(`IDX_LOW_COUNT, 8'hFE);
        repeat (4) @(posedge mclk_i);
        rdchk(`IDX_LOW_COUNT, 8'hF0, 8'hF8, "low own reload");
        rdchk(`IDX_TIMER_CONTROL, 8'h48, 8'h48, "low flag only");
        chk(32'(timer_irq_o), 0, 0, "low without enable");
        wr(`IDX_HIGH_RELOAD, 8'hE0);
        wr(`IDX_HIGH_COUNT, 8'hFE);
        wr(`IDX_TIMER_CONTROL, 8'h4C);
        repeat (4) @(posedge mclk_i);
        rdchk(`IDX_HIGH_COUNT, 8'hE0, 8'hE8, "high own reload");
        rdchk(`IDX_TIMER_CONTROL, 8'hCC, 8'hCC, "both flags");
        chk(32'(timer_irq_o), 1, 1, "high request");
        wr(`IDX_TIMER_CONTROL, 8'h28);
        repeat (40) @(posedge mclk_i);
        chk(32'(timer_irq_o), 1, 1, "low request");
        timer_int_enable_i <= 1'b0;
        @(posedge mclk_i);
        chk(32'(timer_irq_o), 0, 0, "masked");
    endtask
    task t_16bit;
        wr(`IDX_TIMER_CONTROL, 8'h00);
        wr(`IDX_CLOCK_CONTROL, 8'h40);
        wr(`IDX_LOW_RELOAD, 8'h34);
        wr(`IDX_HIGH_RELOAD, 8'h12);
        wr(`IDX_LOW_COUNT, 8'hF8);
        wr(`IDX_HIGH_COUNT, 8'hFF);
        timer_int_enable_i <= 1'b1;
        wr(`IDX_TIMER_CONTROL, 8'h04);
        repeat (20) @(posedge mclk_i);
        rdchk(`IDX_HIGH_COUNT, 8'h12, 8'h12, "wide reload");
        rdchk(`IDX_TIMER_CONTROL, 8'hC4, 8'hC4, "wide flags");
        chk(32'(timer_irq_o), 1, 1, "wide request");
        wr(`IDX_TIMER_CONTROL, 8'h04);
        wr(`IDX_LOW_COUNT, 8'hF0);
        repeat (30) @(posedge mclk_i);
        chk(32'(timer_irq_o), 0, 0, "low byte not enabled");
        rdchk(`IDX_TIMER_CONTROL, 8'h44, 8'h44, "low byte flag");
        wr(`IDX_TIMER_CONTROL, 8'h64);
        chk(32'(timer_irq_o), 1, 1, "low byte enabled");
        wr(`IDX_TIMER_CONTROL, 8'h20);
        chk(32'(timer_irq_o), 0, 0, "flags cleared");
        xfer(1'b0, `IDX_LOW_COUNT, 8'h00);
        repeat (30) @(posedge mclk_i);
        rdchk(`IDX_LOW_COUNT, rd, rd, "stopped");
    endtask
    task t_capture;
        logic [15:0] a;
        logic [15:0] d;
        wr(`IDX_TIMER_CONTROL, 8'h14);
        for (int k = 0; k < 2; k++)
        begin
            while (timer_irq_o !== 1'b1) @(posedge mclk_i);
            xfer(1'b0, `IDX_LOW_RELOAD, 8'h00);
            d[7:0] = rd[7:0];
            xfer(1'b0, `IDX_HIGH_RELOAD, 8'h00);
            d[15:8] = rd[7:0];
            wr(`IDX_TIMER_CONTROL, 8'h14);
            if (k == 1)
                chk({16'h0000, d - a}, 64, 64, "capture spacing");
            a = d;
        end
        // Capture with external select: low clock must stay system/12
        wr(`IDX_CLOCK_CONTROL, 8'h00);
        wr(`IDX_TIMER_CONTROL, 8'h15);
        wr(`IDX_LOW_COUNT, 8'h00);
        repeat (240) @(posedge mclk_i);
        rdchk(`IDX_LOW_COUNT, 19, 22, "capture ignores ext");
    endtask

    // ==========================================
    // Main sequence and watchdog
    initial
    begin
        repeat (3) @(posedge mclk_i);
        rst_i <= 1'b0;
        @(posedge mclk_i);
        t_reset;
        t_rates;
        t_split_ovf;
        t_16bit;
        t_capture;
        end_of_test;
    end
    // Whole run is a few thousand cycles
    initial
    begin
        #1000000;
        fail_count++;
        end_of_test;
    end
endmodule // tb
